// >>> twl_pkg.sv
// Purpose: Shared constants for the three-wire configuration loader
// Assumes: 16-bit words, two-bit address in the low bits
// Notes:   Field positions follow the word layout of each location
package twl_pkg;
	localparam int WORD_W    = 16;
	localparam int ADDR_W    = 2;
	localparam int PAYLOAD_W = 14;
	localparam int FRAC_W    = 28;
	localparam int INT_W     = 8;
	localparam int CNT_W     = 5;

	localparam logic [1:0] ADDR_FRAC_HI = 2'h0;
	localparam logic [1:0] ADDR_FRAC_LO = 2'h1;
	localparam logic [1:0] ADDR_DIVPMP  = 2'h2;
	localparam logic [1:0] ADDR_CFG     = 2'h3;

	// Field positions inside the full shifted word
	localparam int INT_LSB   = 2;
	localparam int CPI_LSB   = 10;
	localparam int LIN_LSB   = 12;
	localparam int REF_LSB   = 14;
	localparam int CPX_POS   = 2;
	localparam int BUFB_POS  = 4;
	localparam int MODB_POS  = 5;
	localparam int PD_POS    = 6;
	localparam int INTM_POS  = 7;
	localparam int TEST_LSB  = 8;
	localparam int BL_LSB    = 14;

	// Power-up contents of each location (payload bits only)
	localparam logic [13:0] RST_FRAC_HI = 14'h2000;
	localparam logic [13:0] RST_FRAC_LO = 14'h0000;
	localparam logic [13:0] RST_DIVPMP  = 14'h03B1;
	localparam logic [13:0] RST_CFG     = 14'h000F;

	// Host clock divider: half period in system clocks
	localparam int SCLK_HALF = 6;
endpackage

// >>> twl_if.sv
// Purpose: Three-wire link between host and loader
// Assumes: Host drives all three lines
// Notes:   Enable is active low
`timescale 1ns/1ps
`default_nettype none
interface twl_if;
	logic sclk;
	logic sdata;
	logic enableN;
	modport host (output sclk, output sdata, output enableN);
	modport dev  (input sclk, input sdata, input enableN);
endinterface
`default_nettype wire

// >>> twl_device.sv
// Purpose: Loader end: shifts serial words, commits them, gates enables
// Assumes: Link lines are asynchronous to clk and are synchronised here
// Notes:   Locations hold payload bits; address bits drop off
// How it works
// - Modulator on when pin and bit high
// - LO buffer on when pin and bit high
// - Ratio is integer plus fraction over 2^28
// - Integer and fraction are plain unsigned binary
// - Fraction upper half addr 00, lower 01
// - Sixteen-bit words into four locations
// - Address 10 holds integer, reference, pump
// - Address 11 holds config, test, compensation
// - Sample data on rising serial clock
// - Shift only while enable is low
// - Enable rise commits word to location
// - Synthesizer off while its pin low
// - Everything off while powerdown pin low
`timescale 1ns/1ps
`default_nettype none
module twl_device
	import twl_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Link
	twl_if.dev                        link,
	// Hardware control pins
	input  wire logic                 modulator_enable_pin,
	input  wire logic                 lo_buffer_enable_pin,
	input  wire logic                 synthesizer_enable_pin,
	input  wire logic                 chip_powerdown_n,
	// Decoded configuration
	output var  logic [INT_W-1:0]     intDivide,
	output var  logic [FRAC_W-1:0]    fracDivide,
	output var  logic [1:0]           refDivide,
	output var  logic [1:0]           pumpCurrent,
	output var  logic [1:0]           pumpLinear,
	output var  logic [1:0]           pumpBleed,
	output var  logic [5:0]           testBits,
	output var  logic                 pumpDouble,
	output var  logic                 softPowerdown,
	output var  logic                 intMode,
	// Gated enables and commit pulse
	output var  logic                 modulatorOn,
	output var  logic                 loBufferOn,
	output var  logic                 synthesizerOn,
	output var  logic                 wordCommit
);
	// ============================================================
	// Field widths of the decoded outputs
	localparam int CP_W    = 2;
	localparam int LIN_W   = 2;
	localparam int REF_W   = 2;
	localparam int BL_W    = 2;
	localparam int TEST_W  = 6;

	// ============================================================
	// Field positions inside a stored payload
	localparam int INT_P   = INT_LSB - ADDR_W;
	localparam int CPI_P   = CPI_LSB - ADDR_W;
	localparam int LIN_P   = LIN_LSB - ADDR_W;
	localparam int REF_P   = REF_LSB - ADDR_W;
	localparam int CPX_P   = CPX_POS - ADDR_W;
	localparam int BUF_P   = BUFB_POS - ADDR_W;
	localparam int MOD_P   = MODB_POS - ADDR_W;
	localparam int PD_P    = PD_POS - ADDR_W;
	localparam int INTM_P  = INTM_POS - ADDR_W;
	localparam int TEST_P  = TEST_LSB - ADDR_W;
	localparam int BL_P    = BL_LSB - ADDR_W;

	// ============================================================
	// Pin positions in the pin synchroniser
	localparam int PIN_MOD = 0;
	localparam int PIN_BUF = 1;
	localparam int PIN_SYN = 2;
	localparam int PIN_PD  = 3;

	// ============================================================
	// Word decoding
	// Address sits in the last two bits shifted in
	function automatic logic [ADDR_W-1:0] addrOf(
		input logic [WORD_W-1:0] word
	);
		return word[ADDR_W-1:0];
	endfunction

	// Payload is the word without its address bits
	function automatic logic [PAYLOAD_W-1:0] payloadOf(
		input logic [WORD_W-1:0] word
	);
		return word[WORD_W-1:ADDR_W];
	endfunction

	// Output gate: chip powered, pin high, software bit high
	function automatic logic gateOf(
		input logic powered,
		input logic pinLevel,
		input logic softBit
	);
		return powered && pinLevel && softBit;
	endfunction

	// ============================================================
	// State
	typedef struct packed {
		logic [1:0]             sclkSync;
		logic [1:0]             dataSync;
		logic [1:0]             enSync;
		logic [3:0]             pinSync1;
		logic [3:0]             pinSync2;
		logic                   sclkPrev;
		logic                   enPrev;
		logic [WORD_W-1:0]      shift;
		logic [PAYLOAD_W-1:0]   fracHi;
		logic [PAYLOAD_W-1:0]   fracLo;
		logic [PAYLOAD_W-1:0]   divPmp;
		logic [PAYLOAD_W-1:0]   cfg;
		logic                   modOn;
		logic                   bufOn;
		logic                   synOn;
		logic                   commit;
	} twl_dev_s;

	twl_dev_s st_q;
	twl_dev_s st_d;

	// ============================================================
	// Next state
	always_comb begin
		st_d          = st_q;
		// Two-flop synchronisers on link and pins
		st_d.sclkSync = {st_q.sclkSync[0], link.sclk};
		st_d.dataSync = {st_q.dataSync[0], link.sdata};
		st_d.enSync   = {st_q.enSync[0], link.enableN};
		st_d.pinSync1 = {chip_powerdown_n, synthesizer_enable_pin,
			lo_buffer_enable_pin, modulator_enable_pin};
		st_d.pinSync2 = st_q.pinSync1;
		// Edge history one stage past the sync
		st_d.sclkPrev = st_q.sclkSync[1];
		st_d.enPrev   = st_q.enSync[1];
		st_d.commit   = 1'b0;
		if (st_q.sclkSync[1] && !st_q.sclkPrev && !st_q.enSync[1]) begin
			st_d.shift = {st_q.shift[WORD_W-2:0], st_q.dataSync[1]};
		end
		// enable rise commits by low bits
		if (st_q.enSync[1] && !st_q.enPrev) begin
			st_d.commit = 1'b1;
			case (addrOf(st_q.shift))
				ADDR_FRAC_HI: st_d.fracHi = payloadOf(st_q.shift);
				ADDR_FRAC_LO: st_d.fracLo = payloadOf(st_q.shift);
				ADDR_DIVPMP:  st_d.divPmp = payloadOf(st_q.shift);
				ADDR_CFG:     st_d.cfg    = payloadOf(st_q.shift);
				default:      st_d.cfg    = st_q.cfg;
			endcase
		end
		st_d.modOn = gateOf(st_q.pinSync2[PIN_PD], st_q.pinSync2[PIN_MOD],
			st_q.cfg[MOD_P]);
		st_d.bufOn = gateOf(st_q.pinSync2[PIN_PD], st_q.pinSync2[PIN_BUF],
			st_q.cfg[BUF_P]);
		st_d.synOn = gateOf(st_q.pinSync2[PIN_PD], st_q.pinSync2[PIN_SYN], 1'b1);
		// Synchronous reset loads power-up contents
		if (!rst_n) begin
			st_d          = '0;
			st_d.sclkSync = 2'h0;
			st_d.enSync   = 2'h3;
			st_d.enPrev   = 1'b1;
			st_d.fracHi   = RST_FRAC_HI;
			st_d.fracLo   = RST_FRAC_LO;
			st_d.divPmp   = RST_DIVPMP;
			st_d.cfg      = RST_CFG;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	// ============================================================
	// Outputs
	// straight binary ratio fields
	assign fracDivide    = {st_q.fracHi, st_q.fracLo};
	assign intDivide     = st_q.divPmp[INT_P +: INT_W];

	// Reference divider and pump setting
	assign pumpCurrent   = st_q.divPmp[CPI_P +: CP_W];
	assign pumpLinear    = st_q.divPmp[LIN_P +: LIN_W];
	assign refDivide     = st_q.divPmp[REF_P +: REF_W];

	// Configuration and test bits
	assign pumpDouble    = st_q.cfg[CPX_P];
	assign softPowerdown = st_q.cfg[PD_P];
	assign intMode       = st_q.cfg[INTM_P];
	assign testBits      = st_q.cfg[TEST_P +: TEST_W];
	assign pumpBleed     = st_q.cfg[BL_P +: BL_W];

	// Gated enables and commit pulse
	assign modulatorOn   = st_q.modOn;
	assign loBufferOn    = st_q.bufOn;
	assign synthesizerOn = st_q.synOn;
	assign wordCommit    = st_q.commit;
endmodule
`default_nettype wire

// >>> twl_host.sv
// Purpose: Host end: sends one 16-bit word per request over the link
// Assumes: Serial clock made here by dividing clk
// Notes:   Data changes on falling serial edge, away from sampling
`timescale 1ns/1ps
`default_nettype none
module twl_host
	import twl_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Request
	input  wire logic               reqValid,
	input  wire logic [WORD_W-1:0]  reqWord,
	output var  logic               reqReady,
	output var  logic               done,
	// Link
	twl_if.host                     link
);
	typedef enum logic [2:0] {
		IDLE  = 3'h1,
		SHIFT = 3'h2,
		LOAD  = 3'h4
	} twl_hst_e;

	typedef struct packed {
		twl_hst_e           state;
		logic [WORD_W-1:0]  word;
		logic [CNT_W-1:0]   bits;
		logic [3:0]         div;
		logic               sclk;
		logic               enN;
		logic               sdata;
		logic               ready;
		logic               done;
	} twl_hst_s;

	twl_hst_s st_q;
	twl_hst_s st_d;

	// ============================================================
	// Sequencer
	always_comb begin
		st_d      = st_q;
		st_d.done = 1'b0;
		case (st_q.state)
			IDLE: begin
				if (reqValid && st_q.ready) begin
					st_d.state = SHIFT;
					st_d.word  = reqWord;
					st_d.bits  = CNT_W'(WORD_W);
					st_d.div   = 4'h0;
					st_d.ready = 1'b0;
					st_d.enN   = 1'b0;
					st_d.sdata = reqWord[WORD_W-1];
				end
			end
			SHIFT: begin
				st_d.div = st_q.div + 4'h1;
				if (st_q.div == 4'(SCLK_HALF - 1)) begin
					st_d.div  = 4'h0;
					st_d.sclk = ~st_q.sclk;
					if (st_q.sclk) begin
						st_d.word  = {st_q.word[WORD_W-2:0], 1'b0};
						st_d.sdata = st_q.word[WORD_W-2];
						st_d.bits  = st_q.bits - CNT_W'(1);
						if (st_q.bits == CNT_W'(1)) begin
							st_d.state = LOAD;
						end
					end
				end
			end
			LOAD: begin
				st_d.div = st_q.div + 4'h1;
				if (st_q.div == 4'(SCLK_HALF - 1)) begin
					st_d.enN   = 1'b1;
					st_d.state = IDLE;
					st_d.ready = 1'b1;
					st_d.done  = 1'b1;
				end
			end
			default: st_d.state = IDLE;
		endcase
		if (!rst_n) begin
			st_d       = '0;
			st_d.state = IDLE;
			st_d.enN   = 1'b1;
			st_d.ready = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign link.sclk    = st_q.sclk;
	assign link.sdata   = st_q.sdata;
	assign link.enableN = st_q.enN;
	assign reqReady     = st_q.ready;
	assign done         = st_q.done;
endmodule
`default_nettype wire

// >>> twl_chk.sv
// Purpose: Link and gating checks for the three-wire loader
// Assumes: One clk domain, rst_n synchronous
// Notes:   Gating lags pins by sync and register stages
`timescale 1ns/1ps
`default_nettype none
module twl_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link
	input wire logic sclk,
	input wire logic sdata,
	input wire logic enableN,
	// Pins and results
	input wire logic modulator_enable_pin,
	input wire logic lo_buffer_enable_pin,
	input wire logic synthesizer_enable_pin,
	input wire logic chip_powerdown_n,
	input wire logic modulatorOn,
	input wire logic loBufferOn,
	input wire logic synthesizerOn,
	input wire logic wordCommit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence frameStart;
		$fell(enableN);
	endsequence
	sequence frameEnd;
		$rose(enableN);
	endsequence
	a_idle_clock_low:
		assert property (enableN |-> !sclk) else $error("sclk high outside frame");
	a_data_stable_rise:
		assert property ($rose(sclk) |-> $stable(sdata)) else $error("data moved at sample");
	a_sclk_half_min:
		assert property ($changed(sclk) |=> $stable(sclk)[*2]) else $error("sclk half short");
	a_frame_min_len:
		assert property (frameStart |-> !enableN[*8]) else $error("frame too short");
	a_commit_after_rise:
		assert property (frameEnd |-> ##[3:5] wordCommit) else $error("no commit");
	a_commit_outside_frame:
		assert property (wordCommit |-> enableN && !$past(wordCommit)) else $error("bad commit");
	a_mod_pin_gate:
		assert property (!modulator_enable_pin[*5] |-> !modulatorOn) else $error("mod on");
	a_buf_pin_gate:
		assert property (!lo_buffer_enable_pin[*5] |-> !loBufferOn) else $error("buf on");
	a_syn_pin_gate:
		assert property (!synthesizer_enable_pin[*5] |-> !synthesizerOn) else $error("syn on");
	a_powerdown_gate:
		assert property (!chip_powerdown_n[*5] |-> !(modulatorOn || loBufferOn || synthesizerOn))
			else $error("on in powerdown");
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Host sends words to loader; results compared
// Assumes: Host and loader joined by one link
// Notes:   Inputs driven at falling clk edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import twl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reqValid = 1'b0;
	logic [WORD_W-1:0] reqWord = '0;
	logic modulator_enable_pin = 1'b1;
	logic lo_buffer_enable_pin = 1'b1;
	logic synthesizer_enable_pin = 1'b1;
	logic chip_powerdown_n = 1'b1;
	logic [7:0] intDivide;
	logic [27:0] fracDivide;
	logic [1:0] refDivide, pumpCurrent, pumpLinear, pumpBleed;
	logic [5:0] testBits;
	logic reqReady, done, pumpDouble, softPowerdown, intMode;
	logic modulatorOn, loBufferOn, synthesizerOn, wordCommit;
	int err_count = 0;
	int total_checks = 0;
	twl_if link();
	twl_host twl_host_i(.clk, .rst_n, .reqValid, .reqWord, .reqReady, .done, .link(link));
	twl_device twl_device_i(.clk, .rst_n, .link(link), .modulator_enable_pin,
		.lo_buffer_enable_pin, .synthesizer_enable_pin, .chip_powerdown_n, .intDivide,
		.fracDivide, .refDivide, .pumpCurrent, .pumpLinear, .pumpBleed, .testBits,
		.pumpDouble, .softPowerdown, .intMode, .modulatorOn, .loBufferOn,
		.synthesizerOn, .wordCommit);
	twl_chk twl_chk_i(.clk, .rst_n, .sclk(link.sclk), .sdata(link.sdata),
		.enableN(link.enableN), .modulator_enable_pin, .lo_buffer_enable_pin,
		.synthesizer_enable_pin, .chip_powerdown_n, .modulatorOn, .loBufferOn,
		.synthesizerOn, .wordCommit);
	always #5 clk = ~clk;
	task automatic chk(input string n, input logic [27:0] s, input logic [27:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic send(input logic [15:0] w);
		int i;
		@(negedge clk);
		chk("reqReady", 28'(reqReady), 28'h1);
		reqValid = 1'b1;
		reqWord = w;
		@(negedge clk);
		reqValid = 1'b0;
		chk("reqReady", 28'(reqReady), 28'h0);
		chk("enableN", 28'(link.enableN), 28'h0);
		for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
		chk("done", 28'(done), 28'h1);
		chk("enableN", 28'(link.enableN), 28'h1);
		repeat (8) @(negedge clk);
	endtask
	task automatic pin(input logic [3:0] p, input logic [2:0] e);
		{modulator_enable_pin, lo_buffer_enable_pin, synthesizer_enable_pin,
			chip_powerdown_n} = p;
		repeat (6) @(negedge clk);
		chk("enables", 28'({modulatorOn, loBufferOn, synthesizerOn}), 28'(e));
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("fracDivide", fracDivide, 28'h8000000);
		chk("intDivide", 28'(intDivide), 28'hB1);
		pin(4'hF, 3'b111);
		send(16'h0E64);
		send(16'h9999);
		chk("fracDivide", fracDivide, 28'hE66666);
		send(16'hD95A);
		chk("divider", 28'({intDivide, refDivide, pumpLinear, pumpCurrent}), 28'h15B6);
		send(16'hADE3);
		chk("config",
			28'({testBits, pumpBleed, intMode, softPowerdown, pumpDouble}), 28'h5B6);
		pin(4'hF, 3'b101);
		pin(4'h7, 3'b001);
		pin(4'hD, 3'b100);
		send(16'hADD3);
		pin(4'hF, 3'b011);
		pin(4'hB, 3'b001);
		pin(4'hE, 3'b000);
		end_of_test();
	end
endmodule
`default_nettype wire
